// *** scgc_ctrl.v ***
`timescale 1ns/10ps
`default_nettype none
`include "scgc_consts.vh"
module scgc_ctrl (
  input wire clk,
  input wire reset,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire sleep_exec,
  input wire xtal_clock_sel,
  input wire [15:0] startup_cycles,
  input wire adc_enabled,
  input wire ext0_level_mode,
  input wire [1:0] timer2_irq_mask,
  input wire global_irq_en,
  input wire t2_running,
  input wire t2_async,
  input wire lcd_running,
  input wire lcd_async,
  input wire adc_done_irq,
  input wire lcd_irq,
  input wire serial_start_irq,
  input wire t2_ovf_irq,
  input wire t2_cmp_irq,
  input wire spm_ready_irq,
  input wire ext_irq_zero,
  input wire pin_change_irq,
  input wire other_io_irq,
  input wire ext_reset_evt,
  input wire wdt_reset_evt,
  input wire bod_reset_evt,
  output reg cpu_clk_en,
  output reg flash_clk_en,
  output reg io_clk_en,
  output reg adc_clk_en,
  output reg async_clock_en,
  output reg main_osc_en,
  output reg timer_osc_en,
  output reg t2lcd_sync_clk_en,
  output reg lcd_clk_en,
  output reg timer1_clk_en,
  output reg spi_clk_en,
  output reg usart_clk_en,
  output reg adc_periph_clk_en,
  output reg [4:0] periph_reg_block,
  output reg comparator_mux_deny,
  output reg adc_conv_start,
  output reg irq_resume,
  output reg reset_wake
);

  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;

  // ==========================================================
  // Helpers
  function [2:0] eff_mode;
    input [2:0] sel;
    input xtal;
    begin
      case (sel)
        `SCGC_MODE_ADCNR: eff_mode = `SCGC_MODE_ADCNR;
        `SCGC_MODE_PDOWN: eff_mode = `SCGC_MODE_PDOWN;
        `SCGC_MODE_PSAVE: eff_mode = `SCGC_MODE_PSAVE;
        `SCGC_MODE_STBY: eff_mode = xtal ? `SCGC_MODE_STBY :
          `SCGC_MODE_IDLE;
        default: eff_mode = `SCGC_MODE_IDLE;
      endcase
    end
  endfunction

  function [7:0] wake_mask;
    input [2:0] mode;
    begin
      case (mode)
        `SCGC_MODE_ADCNR: wake_mask = `SCGC_MASK_ADCNR;
        `SCGC_MODE_PDOWN: wake_mask = `SCGC_MASK_PDOWN;
        `SCGC_MODE_PSAVE: wake_mask = `SCGC_MASK_PSAVE;
        `SCGC_MODE_STBY: wake_mask = `SCGC_MASK_STBY;
        default: wake_mask = `SCGC_MASK_IDLE;
      endcase
    end
  endfunction

  // ==========================================================
  // Wake source synchronisers
  wire [11:0] wk_raw;
  reg [11:0] wk_s1_q;
  reg [11:0] wk_s2_q;
  assign wk_raw = {bod_reset_evt, wdt_reset_evt, ext_reset_evt,
    other_io_irq, pin_change_irq, ext_irq_zero, spm_ready_irq,
    t2_cmp_irq, t2_ovf_irq, serial_start_irq, lcd_irq, adc_done_irq};

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wk_s1_q <= 12'h000;
      wk_s2_q <= 12'h000;
    end else begin
      wk_s1_q <= wk_raw;
      wk_s2_q <= wk_s1_q;
    end
  end

  // ==========================================================
  // Registers and bus
  reg arm_q;
  reg [2:0] sel_q;
  reg [4:0] stop_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] mode_q;
  reg [2:0] mode_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg acc_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  wire req;
  wire take;

  assign req = avs_read | avs_write;
  assign take = req & acc_q;
  assign avs_waitrequest = req & ~acc_q;
  assign avs_readdata = rdata_q;

  always @* begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `SCGC_OFS_SLEEP_CTRL: begin
        rdata_d[`SCGC_ARM_BIT] = arm_q;
        rdata_d[`SCGC_SEL_MSB:`SCGC_SEL_LSB] = sel_q;
      end
      `SCGC_OFS_CLK_STOP: rdata_d[4:0] = stop_q;
      `SCGC_OFS_STATUS: begin
        rdata_d[`SCGC_STAT_STATE_LSB +: 3] = state_q;
        rdata_d[`SCGC_STAT_MODE_LSB +: 3] = mode_q;
      end
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_q <= 1'b0;
      rdata_q <= 32'h00000000;
      {sel_q, arm_q} <= `SCGC_RST_SLEEP_CTRL;
      stop_q <= `SCGC_RST_CLK_STOP;
    end else begin
      acc_q <= req & ~acc_q;
      if (avs_read && !acc_q) begin
        rdata_q <= rdata_d;
      end
      if (take && avs_write && avs_byteenable[0]) begin
        if (avs_address == `SCGC_OFS_SLEEP_CTRL) begin
          arm_q <= avs_writedata[`SCGC_ARM_BIT];
          sel_q <= avs_writedata[`SCGC_SEL_MSB:`SCGC_SEL_LSB];
        end
        if (avs_address == `SCGC_OFS_CLK_STOP) begin
          stop_q <= avs_writedata[`SCGC_STOP_WIDTH-1:0];
        end
      end
    end
  end

  // ==========================================================
  // Wake qualification
  wire asy_use;
  wire syn_use;
  wire t2_wake;
  wire ext0_ok;
  wire [7:0] wk_src;
  wire wake_any;
  wire rst_any;

  assign asy_use = (t2_running & t2_async) | (lcd_running & lcd_async);
  assign syn_use = (t2_running & ~t2_async) | (lcd_running & ~lcd_async);
  assign t2_wake = ((wk_s2_q[3] & timer2_irq_mask[0]) |
    (wk_s2_q[4] & timer2_irq_mask[1])) & global_irq_en;
  assign ext0_ok = wk_s2_q[6] &
    (ext0_level_mode | (mode_q == `SCGC_MODE_IDLE));
  assign wk_src = {wk_s2_q[8], wk_s2_q[7], ext0_ok, wk_s2_q[5],
    t2_wake, wk_s2_q[2], wk_s2_q[1], wk_s2_q[0]};
  assign wake_any = |(wk_src & wake_mask(mode_q));
  assign rst_any = |wk_s2_q[11:9];

  // ==========================================================
  // Sleep sequencer
  reg conv_d;
  reg resume_d;
  reg rwake_d;
  reg [2:0] entry_mode;

  always @* begin
    state_d = state_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    conv_d = 1'b0;
    resume_d = 1'b0;
    rwake_d = 1'b0;
    entry_mode = eff_mode(sel_q, xtal_clock_sel);
    case (state_q)
      ST_RUN: begin
        if (sleep_exec && arm_q) begin
          state_d = ST_SLEEP;
          mode_d = entry_mode;
          conv_d = adc_enabled & ~stop_q[`SCGC_STOP_ADC] &
            ((entry_mode == `SCGC_MODE_ADCNR) |
            (entry_mode == `SCGC_MODE_IDLE));
        end
      end
      ST_SLEEP: begin
        if (rst_any) begin
          state_d = ST_RUN;
          rwake_d = 1'b1;
        end else if (wake_any) begin
          case (mode_q)
            `SCGC_MODE_PDOWN, `SCGC_MODE_PSAVE: begin
              state_d = ST_START;
              cnt_d = startup_cycles;
            end
            `SCGC_MODE_STBY: begin
              state_d = ST_START;
              cnt_d = `SCGC_STBY_CYCLES;
            end
            default: begin
              state_d = ST_HOLD;
              cnt_d = `SCGC_HOLD_CYCLES;
            end
          endcase
        end
      end
      ST_START: begin
        if (rst_any) begin
          state_d = ST_RUN;
          rwake_d = 1'b1;
        end else if (cnt_q <= 16'h0001) begin
          state_d = ST_HOLD;
          cnt_d = `SCGC_HOLD_CYCLES;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_HOLD: begin
        if (rst_any) begin
          state_d = ST_RUN;
          rwake_d = 1'b1;
        end else if (cnt_q <= 16'h0001) begin
          state_d = ST_RUN;
          resume_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // ==========================================================
  // Clock gating
  reg run_d;
  reg slp_d;
  reg hold_d;
  reg idle_d;
  reg adcnr_d;
  reg pd_d;
  reg ps_d;
  reg stby_d;
  reg io_d;
  reg sync_d;

  always @* begin
    run_d = (state_d == ST_RUN);
    slp_d = (state_d == ST_SLEEP);
    hold_d = (state_d == ST_HOLD);
    idle_d = (mode_d == `SCGC_MODE_IDLE);
    adcnr_d = (mode_d == `SCGC_MODE_ADCNR);
    pd_d = (mode_d == `SCGC_MODE_PDOWN);
    ps_d = (mode_d == `SCGC_MODE_PSAVE);
    stby_d = (mode_d == `SCGC_MODE_STBY);
    io_d = run_d | hold_d | (slp_d & idle_d);
    sync_d = io_d | (~run_d & ~hold_d & ps_d & syn_use);
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_RUN;
      mode_q <= `SCGC_MODE_IDLE;
      cnt_q <= 16'h0000;
      cpu_clk_en <= 1'b1;
      flash_clk_en <= 1'b1;
      io_clk_en <= 1'b1;
      adc_clk_en <= 1'b1;
      async_clock_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b0;
      t2lcd_sync_clk_en <= 1'b1;
      lcd_clk_en <= 1'b1;
      timer1_clk_en <= 1'b1;
      spi_clk_en <= 1'b1;
      usart_clk_en <= 1'b1;
      adc_periph_clk_en <= 1'b1;
      periph_reg_block <= 5'h00;
      comparator_mux_deny <= 1'b0;
      adc_conv_start <= 1'b0;
      irq_resume <= 1'b0;
      reset_wake <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      cpu_clk_en <= run_d;
      flash_clk_en <= run_d;
      io_clk_en <= io_d;
      adc_clk_en <= io_d | (slp_d & adcnr_d);
      async_clock_en <= io_d | (slp_d & adcnr_d) | (~run_d & ps_d);
      main_osc_en <= ~(slp_d & (pd_d | (ps_d & ~syn_use)));
      timer_osc_en <= asy_use & ~(~run_d & (pd_d | stby_d));
      t2lcd_sync_clk_en <= sync_d;
      lcd_clk_en <= sync_d & ~stop_q[`SCGC_STOP_LCD];
      timer1_clk_en <= io_d & ~stop_q[`SCGC_STOP_TIMER1];
      spi_clk_en <= io_d & ~stop_q[`SCGC_STOP_SPI];
      usart_clk_en <= io_d & ~stop_q[`SCGC_STOP_USART];
      adc_periph_clk_en <= (io_d | (slp_d & adcnr_d)) &
        ~stop_q[`SCGC_STOP_ADC];
      periph_reg_block <= stop_q;
      comparator_mux_deny <= stop_q[`SCGC_STOP_ADC];
      adc_conv_start <= conv_d;
      irq_resume <= resume_d;
      reset_wake <= rwake_d;
    end
  end

endmodule // scgc_ctrl
`default_nettype wire

// *** scgc_consts.vh ***
`ifndef SCGC_CONSTS_VH
`define SCGC_CONSTS_VH
// ==========================================================
// Register byte offsets
`define SCGC_OFS_SLEEP_CTRL 4'h0
`define SCGC_OFS_CLK_STOP 4'h4
`define SCGC_OFS_STATUS 4'h8
// ==========================================================
// Sleep control fields
`define SCGC_ARM_BIT 0
`define SCGC_SEL_LSB 1
`define SCGC_SEL_MSB 3
// ==========================================================
// Peripheral clock stop fields
`define SCGC_STOP_ADC 0
`define SCGC_STOP_USART 1
`define SCGC_STOP_SPI 2
`define SCGC_STOP_TIMER1 3
`define SCGC_STOP_LCD 4
`define SCGC_STOP_WIDTH 5
// ==========================================================
// Status fields
`define SCGC_STAT_STATE_LSB 0
`define SCGC_STAT_MODE_LSB 4
// ==========================================================
// Reset values
`define SCGC_RST_SLEEP_CTRL 4'h0
`define SCGC_RST_CLK_STOP 5'h00
// ==========================================================
// Sleep mode encodings
`define SCGC_MODE_IDLE 3'h0
`define SCGC_MODE_ADCNR 3'h1
`define SCGC_MODE_PDOWN 3'h2
`define SCGC_MODE_PSAVE 3'h3
`define SCGC_MODE_STBY 3'h6
// ==========================================================
// Wake source bit positions
`define SCGC_WK_ADC 0
`define SCGC_WK_LCD 1
`define SCGC_WK_SERIAL 2
`define SCGC_WK_T2 3
`define SCGC_WK_SPM 4
`define SCGC_WK_EXT0 5
`define SCGC_WK_PCHG 6
`define SCGC_WK_IO 7
// ==========================================================
// Wake source masks per mode
`define SCGC_MASK_IDLE 8'hFF
`define SCGC_MASK_ADCNR 8'h7F
`define SCGC_MASK_PDOWN 8'h64
`define SCGC_MASK_PSAVE 8'h6E
`define SCGC_MASK_STBY 8'h64
// ==========================================================
// Timing counts in clock cycles
`define SCGC_HOLD_CYCLES 16'h0004
`define SCGC_STBY_CYCLES 16'h0006
`endif

// *** scgc_ctrl_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module scgc_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic adc_enabled,
  input wire logic cpu_clk_en,
  input wire logic io_clk_en,
  input wire logic main_osc_en,
  input wire logic usart_clk_en,
  input wire logic [4:0] periph_reg_block,
  input wire logic comparator_mux_deny,
  input wire logic adc_conv_start,
  input wire logic irq_resume
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Register bus
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait cycle");
  property p_first_wait;
    $rose(avs_read) |-> avs_waitrequest;
  endproperty
  a_first_wait: assert property (p_first_wait)
    else $error("read answered without wait");
  property p_stop_rd;
    avs_read && !avs_waitrequest && avs_address == 4'h4
      |-> avs_readdata[31:5] == 27'h0;
  endproperty
  a_stop_rd: assert property (p_stop_rd)
    else $error("reserved stop bits not zero");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 4'hC
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  // ==========================================================
  // Peripheral gating
  property p_stop_write;
    avs_write && !avs_waitrequest && avs_address == 4'h4 &&
      avs_byteenable[0] |=> ##1
      periph_reg_block == $past(avs_writedata[4:0], 2);
  endproperty
  a_stop_write: assert property (p_stop_write)
    else $error("stop bits not applied");
  property p_usart;
    periph_reg_block[1] |-> !usart_clk_en;
  endproperty
  a_usart: assert property (p_usart)
    else $error("usart clock runs while stopped");
  property p_deny;
    avs_write && !avs_waitrequest && avs_address == 4'h4 &&
      avs_byteenable[0] |=> ##1
      comparator_mux_deny == $past(avs_writedata[0], 2);
  endproperty
  a_deny: assert property (p_deny)
    else $error("comparator mux deny wrong");
  // ==========================================================
  // Sleep gating
  property p_io_cpu;
    !io_clk_en |-> !cpu_clk_en;
  endproperty
  a_io_cpu: assert property (p_io_cpu)
    else $error("cpu clock runs with io clock off");
  property p_osc;
    !main_osc_en |-> !io_clk_en;
  endproperty
  a_osc: assert property (p_osc)
    else $error("io clock runs with oscillator off");
  property p_conv;
    adc_conv_start |-> adc_enabled && !cpu_clk_en;
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion start outside sleep");
  property p_resume;
    irq_resume |-> cpu_clk_en ##1 !irq_resume;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume pulse without cpu clock");
endmodule // scgc_chk
bind scgc_ctrl scgc_chk u_chk (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .adc_enabled(adc_enabled), .cpu_clk_en(cpu_clk_en),
  .io_clk_en(io_clk_en), .main_osc_en(main_osc_en),
  .usart_clk_en(usart_clk_en), .periph_reg_block(periph_reg_block),
  .comparator_mux_deny(comparator_mux_deny),
  .adc_conv_start(adc_conv_start), .irq_resume(irq_resume));
`default_nettype wire

// *** scgc_far_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module scgc_far_end (
  input wire logic clk,
  input wire logic reset,
  input wire logic fire,
  input wire logic [3:0] fire_idx,
  input wire logic irq_resume,
  input wire logic reset_wake,
  output logic [11:0] src
);
  // Sources hold their level until the wake is seen
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      src <= 12'h000;
    end else if (irq_resume || reset_wake) begin
      src <= 12'h000;
    end else if (fire) begin
      src[fire_idx] <= 1'b1;
    end
  end
endmodule // scgc_far_end
`default_nettype wire

// *** test_sleep_clock_gating_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_sleep_clock_gating_ctrl;
  logic clk = 0, reset = 1, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, v, exp_q[$];
  logic sleep_exec = 0, fire = 0, adc_enabled = 0, xtal_clock_sel = 1;
  logic ext0_level_mode = 1, global_irq_en = 0, t2_running = 0;
  logic t2_async = 0, lcd_running = 0, lcd_async = 0;
  logic [1:0] timer2_irq_mask = 2'h0;
  logic [15:0] startup_cycles = 16'h0003;
  logic [3:0] fire_idx = 4'h0;
  logic [11:0] src;
  wire [31:0] avs_readdata;
  wire [4:0] periph_reg_block;
  wire avs_waitrequest, cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en;
  wire async_clock_en, main_osc_en, timer_osc_en, t2lcd_sync_clk_en;
  wire lcd_clk_en, timer1_clk_en, spi_clk_en, usart_clk_en;
  wire adc_periph_clk_en, comparator_mux_deny, adc_conv_start;
  wire irq_resume, reset_wake;
  int errors = 0, comparisons = 0, seed = 80, conv_n = 0, n0, k, i;
  int ks[6];
  localparam logic [17:0] mode_tab = {3'h5, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [29:0] exp_tab = {5'h17, 5'h01, 5'h00, 5'h00, 5'h13,
    5'h17};
  localparam logic [23:0] exp2_tab = {4'h5, 4'h0, 4'h4, 4'h0, 4'h4, 4'h5};
  scgc_ctrl u_dut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_exec(sleep_exec), .xtal_clock_sel(xtal_clock_sel),
    .startup_cycles(startup_cycles), .adc_enabled(adc_enabled),
    .ext0_level_mode(ext0_level_mode), .timer2_irq_mask(timer2_irq_mask),
    .global_irq_en(global_irq_en), .t2_running(t2_running),
    .t2_async(t2_async), .lcd_running(lcd_running), .lcd_async(lcd_async),
    .adc_done_irq(src[0]), .lcd_irq(src[1]),
    .serial_start_irq(src[2]), .t2_ovf_irq(src[3]), .t2_cmp_irq(src[4]),
    .spm_ready_irq(src[5]), .ext_irq_zero(src[6]),
    .pin_change_irq(src[7]), .other_io_irq(src[8]),
    .ext_reset_evt(src[9]), .wdt_reset_evt(src[10]),
    .bod_reset_evt(src[11]), .cpu_clk_en(cpu_clk_en),
    .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
    .adc_clk_en(adc_clk_en), .async_clock_en(async_clock_en),
    .main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en),
    .t2lcd_sync_clk_en(t2lcd_sync_clk_en), .lcd_clk_en(lcd_clk_en),
    .timer1_clk_en(timer1_clk_en), .spi_clk_en(spi_clk_en),
    .usart_clk_en(usart_clk_en), .adc_periph_clk_en(adc_periph_clk_en),
    .periph_reg_block(periph_reg_block),
    .comparator_mux_deny(comparator_mux_deny),
    .adc_conv_start(adc_conv_start), .irq_resume(irq_resume),
    .reset_wake(reset_wake));
  scgc_far_end u_far (.clk(clk), .reset(reset), .fire(fire),
    .fire_idx(fire_idx), .irq_resume(irq_resume),
    .reset_wake(reset_wake), .src(src));
  always #2 clk = ~clk;
  // ==========================================================
  // Checking
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      chk("readdata", exp_q.pop_front(), avs_readdata);
    end
    if (adc_conv_start === 1'b1) begin
      conv_n++;
    end
  end
  task tally_and_finish;
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Drivers
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task slp(input logic [2:0] m);
    repeat (3) @(posedge clk);
    bus(1'b1, 4'h0, {28'h0, m, 1'b1});
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task wake(input logic [3:0] idx);
    fire_idx <= idx;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    k = 0;
    while ((irq_resume | reset_wake) !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(4'h4, 32'h0);
    rd(4'hC, 32'h0);
    repeat (4) begin
      v = $random(seed);
      bus(1'b1, 4'h4, v);
      rd(4'h4, {27'h0, v[4:0]});
      chk("clk_en", {27'h0, ~v[4:0]}, {27'h0, lcd_clk_en, timer1_clk_en,
        spi_clk_en, usart_clk_en, adc_periph_clk_en});
      chk("deny", {31'h0, v[0]}, {31'h0, comparator_mux_deny});
    end
    avs_byteenable <= 4'hE;
    bus(1'b1, 4'h4, 32'h0);
    avs_byteenable <= 4'hF;
    rd(4'h4, {27'h0, v[4:0]});
    bus(1'b1, 4'h4, 32'h0);
    rd(4'h4, 32'h0);
    chk("clk_en", 32'h1F, {27'h0, lcd_clk_en, timer1_clk_en, spi_clk_en,
      usart_clk_en, adc_periph_clk_en});
    adc_enabled <= 1'b1;
    for (i = 0; i < 6; i++) begin
      n0 = conv_n;
      slp(mode_tab[i*3 +: 3]);
      chk("domains", {27'h0, exp_tab[i*5 +: 5]}, {27'h0, conv_n != n0,
        cpu_clk_en, io_clk_en, adc_clk_en, main_osc_en});
      chk("domains2", {28'h0, exp2_tab[i*4 +: 4]}, {28'h0, flash_clk_en,
        async_clock_en, timer_osc_en, t2lcd_sync_clk_en});
      wake(4'h7);
      chk("resume", 32'h1, {31'h0, irq_resume});
      ks[i] = k;
    end
    chk("pd_delay", ks[0] + 3, ks[2]);
    chk("ps_delay", ks[0] + 3, ks[3]);
    chk("stby_delay", ks[0] + 6, ks[4]);
    chk("hold", 8, ks[0]);
    slp(3'h2);
    ext0_level_mode <= 1'b0;
    wake(4'h0);
    chk("no_wake", 40, k);
    wake(4'h6);
    chk("no_wake", 40, k);
    wake(4'hA);
    chk("reset_wake", 32'h1, {31'h0, reset_wake});
    rd(4'h8, 32'h20);
    ext0_level_mode <= 1'b1;
    slp(3'h2);
    wake(4'h6);
    chk("ext0_wake", 32'h1, {31'h0, irq_resume});
    t2_running <= 1'b1;
    t2_async <= 1'b1;
    timer2_irq_mask <= 2'h1;
    slp(3'h3);
    chk("t2_osc", 32'h4, {29'h0, timer_osc_en, main_osc_en,
      t2lcd_sync_clk_en});
    wake(4'h3);
    chk("no_wake", 40, k);
    global_irq_en <= 1'b1;
    wake(4'h3);
    chk("t2_wake", 32'h1, {31'h0, irq_resume});
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule // test_sleep_clock_gating_ctrl
`default_nettype wire
